// ==== tsr_pkg.sv ====
// tsr_pkg: constants, command codes and carrier types for the temperature sensor register core.
// assumes a single core clock domain; the serial framer outside delivers whole command bytes.
package tsr_pkg;

  // command bytes seen on the command port
  localparam logic [7:0] CMD_RD_TEMP  = 8'hC1;
  localparam logic [7:0] CMD_RD_CFG   = 8'hC3;
  localparam logic [7:0] CMD_WR_CFG   = 8'h83;
  localparam logic [7:0] CMD_RD_HYST  = 8'hC5;
  localparam logic [7:0] CMD_WR_HYST  = 8'h85;
  localparam logic [7:0] CMD_RD_CRIT  = 8'hC7;
  localparam logic [7:0] CMD_WR_CRIT  = 8'h87;
  localparam logic [7:0] CMD_RD_LOW   = 8'hC9;
  localparam logic [7:0] CMD_WR_LOW   = 8'h89;
  localparam logic [7:0] CMD_RD_HIGH  = 8'hCB;
  localparam logic [7:0] CMD_WR_HIGH  = 8'h8B;

  // configuration field positions and writable mask
  localparam int         CFG_SHDN_BIT   = 8;
  localparam int         CFG_INTMODE_BIT = 9;
  localparam int         CFG_OTPOL_BIT  = 10;
  localparam int         CFG_WPOL_BIT   = 11;
  localparam int         CFG_QUEUE_BIT  = 12;
  localparam logic [15:0] CFG_WR_MASK   = 16'h1F00;
  localparam logic [15:0] CFG_RESET     = 16'h0000;

  // limit registers keep sign plus eight bits, the low seven are dropped
  localparam logic [15:0] LIM_WR_MASK   = 16'hFF80;
  localparam int          LIM_LSB       = 7;
  localparam logic [15:0] HYST_RESET    = 16'h0100;
  localparam logic [15:0] CRIT_RESET    = 16'h2800;
  localparam logic [15:0] LOW_RESET     = 16'h0500;
  localparam logic [15:0] HIGH_RESET    = 16'h2000;

  // temperature word layout: 13-bit reading above three flags
  localparam int          TEMP_LSB      = 3;
  localparam int          FLAG_HIGH_BIT = 2;
  localparam int          FLAG_LOW_BIT  = 1;
  localparam int          FLAG_CRIT_BIT = 0;
  localparam logic [15:0] TEMP_RESET    = 16'h0000;

  // consecutive faults needed when the fault queue is on
  localparam logic [2:0]  QUEUE_DEPTH   = 3'h4;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } tsr_cmd_t;

endpackage

// ==== tsr_core.sv ====
// tsr_core: register core of a 13-bit temperature sensor with warning and critical outputs.
// assumes a serial framer on core_clk hands over one command with its write word per cmd_valid,
// and the converter delivers readings on core_clk, so no input needs synchronising.
//
// Summary of operation
// - reading is two's complement, 1/16 degree steps
// - lowest three temperature bits are status flags
// - temperature register read-only, read by C1h
// - configuration keeps only bits 8 to 12
// - shutdown bit stops all but interface, reset
// - fault queue demands four faults in a row
// - configuration read by C3h, written by 83h
// - limits use top nine bits, one degree
// - warning from high, low and hysteresis limits
// - critical output from critical and hysteresis limits
// - reserved bits discarded, limits read and write
// - reset loads hysteresis 2 and critical 80 degrees
// - reset loads low 10 and high 64 degrees
// - polarity bits, interrupt mode, config clears
`timescale 1ns/1ps
`default_nettype none

module tsr_core
  import tsr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic        cmd_valid,
  input  wire tsr_cmd_t    cmd_req,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  input  wire logic        sample_valid,
  input  wire logic [12:0] sample_temp,
  output logic             conv_enable,
  output logic             warn_output,
  output logic             overtemp_output
);

  // whole degrees of a word: sign plus eight bits, widened so sums cannot overflow
  function automatic logic signed [9:0] deg_of(input logic [15:0] w);
    deg_of = $signed({w[15], w[15:LIM_LSB]});
  endfunction

  // saturating consecutive-fault counter step
  function automatic logic [2:0] queue_step(input logic hit, input logic [2:0] cnt);
    if (!hit) begin
      queue_step = 3'h0;
    end else if (cnt >= QUEUE_DEPTH) begin
      queue_step = cnt;
    end else begin
      queue_step = cnt + 3'h1;
    end
  endfunction

  logic [15:0] temp_reg;
  logic [15:0] cfg_reg;
  logic [15:0] hyst_reg;
  logic [15:0] crit_reg;
  logic [15:0] low_reg;
  logic [15:0] high_reg;
  logic [2:0]  warn_cnt_reg;
  logic [2:0]  crit_cnt_reg;
  logic        warn_act_reg;
  logic        crit_act_reg;

  logic              shutdown;
  logic              take_sample;
  logic              temp_read;
  logic              is_write;
  logic              rd_cmd;
  logic              wr_cfg;
  logic              wr_hyst;
  logic              wr_crit;
  logic              wr_low;
  logic              wr_high;
  logic              rd_cfg;
  logic              rd_hyst;
  logic              rd_crit;
  logic              rd_low;
  logic              rd_high;
  logic [15:0]       sample_word;
  logic signed [9:0] now_deg;
  logic signed [9:0] high_deg;
  logic signed [9:0] low_deg;
  logic signed [9:0] crit_deg;
  logic signed [9:0] hyst_deg;
  logic              hi_hit;
  logic              lo_hit;
  logic              crit_hit;
  logic              warn_clear;
  logic              crit_clear;
  logic              warn_release;
  logic              crit_release;
  logic [2:0]        warn_cnt_next;
  logic [2:0]        crit_cnt_next;
  logic              warn_fire;
  logic              crit_fire;

  // conversions are held off while shut down; registers and the command port stay live
  assign shutdown    = cfg_reg[CFG_SHDN_BIT];
  assign conv_enable = ~shutdown;
  assign take_sample = sample_valid & ~shutdown;
  assign temp_read   = cmd_valid & (cmd_req.cmd == CMD_RD_TEMP);
  assign is_write    = cmd_valid & ~cmd_req.cmd[6];
  assign rd_cmd      = cmd_valid & cmd_req.cmd[6];

  // write strobes decoded once, so each register process stays small
  assign wr_cfg  = is_write & (cmd_req.cmd == CMD_WR_CFG);
  assign wr_hyst = is_write & (cmd_req.cmd == CMD_WR_HYST);
  assign wr_crit = is_write & (cmd_req.cmd == CMD_WR_CRIT);
  assign wr_low  = is_write & (cmd_req.cmd == CMD_WR_LOW);
  assign wr_high = is_write & (cmd_req.cmd == CMD_WR_HIGH);

  // read selects; a write code with bit 6 clear never reaches the read mux
  assign rd_cfg  = cmd_req.cmd == CMD_RD_CFG;
  assign rd_hyst = cmd_req.cmd == CMD_RD_HYST;
  assign rd_crit = cmd_req.cmd == CMD_RD_CRIT;
  assign rd_low  = cmd_req.cmd == CMD_RD_LOW;
  assign rd_high = cmd_req.cmd == CMD_RD_HIGH;

  // reading sits above the flags, each LSB worth a sixteenth of a degree
  assign sample_word = {sample_temp, 3'h0};
  assign now_deg     = deg_of(sample_word);

  // limits in whole degrees; the low seven bits never take part
  assign high_deg = deg_of(high_reg);
  assign low_deg  = deg_of(low_reg);
  assign crit_deg = deg_of(crit_reg);
  assign hyst_deg = deg_of(hyst_reg);

  // threshold checks; ten bits hold any limit plus or minus hysteresis
  assign hi_hit     = now_deg >= high_deg;
  assign lo_hit     = now_deg < low_deg;
  assign warn_clear = (now_deg < (high_deg - hyst_deg)) &&
                      (now_deg >= (low_deg + hyst_deg));
  assign crit_hit   = now_deg >= crit_deg;
  assign crit_clear = now_deg < (crit_deg - hyst_deg);

  // with the queue on a fault counts only on the fourth reading in a row
  assign warn_cnt_next = queue_step(hi_hit | lo_hit, warn_cnt_reg);
  assign crit_cnt_next = queue_step(crit_hit, crit_cnt_reg);
  assign warn_fire = cfg_reg[CFG_QUEUE_BIT] ? (warn_cnt_next >= QUEUE_DEPTH)
                                            : (hi_hit | lo_hit);
  assign crit_fire = cfg_reg[CFG_QUEUE_BIT] ? (crit_cnt_next >= QUEUE_DEPTH)
                                            : crit_hit;

  // interrupt mode releases on a temperature read, comparator mode on hysteresis
  assign warn_release = cfg_reg[CFG_INTMODE_BIT] ? temp_read : (take_sample && warn_clear);
  assign crit_release = cfg_reg[CFG_INTMODE_BIT] ? temp_read : (take_sample && crit_clear);

  // temperature word: hardware only, no command writes it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      temp_reg <= TEMP_RESET;
    end else if (clk_en && take_sample) begin
      temp_reg[15:TEMP_LSB]     <= sample_temp;
      temp_reg[FLAG_HIGH_BIT]   <= hi_hit;
      temp_reg[FLAG_LOW_BIT]    <= lo_hit;
      temp_reg[FLAG_CRIT_BIT]   <= crit_hit;
    end
  end

  // configuration: only the five control bits are stored, the rest read zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_reg <= CFG_RESET;
    end else if (clk_en && wr_cfg) begin
      cfg_reg <= cmd_req.wdata & CFG_WR_MASK;
    end
  end

  // hysteresis limit; masked low bits keep reads honest about what is held
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hyst_reg <= HYST_RESET;
    end else if (clk_en && wr_hyst) begin
      hyst_reg <= cmd_req.wdata & LIM_WR_MASK;
    end
  end

  // critical limit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      crit_reg <= CRIT_RESET;
    end else if (clk_en && wr_crit) begin
      crit_reg <= cmd_req.wdata & LIM_WR_MASK;
    end
  end

  // lower warning limit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      low_reg <= LOW_RESET;
    end else if (clk_en && wr_low) begin
      low_reg <= cmd_req.wdata & LIM_WR_MASK;
    end
  end

  // upper warning limit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      high_reg <= HIGH_RESET;
    end else if (clk_en && wr_high) begin
      high_reg <= cmd_req.wdata & LIM_WR_MASK;
    end
  end

  // warning queue advances once per accepted reading, frozen during shutdown
  always_ff @(posedge core_clk) begin
    if (srst) begin
      warn_cnt_reg <= 3'h0;
    end else if (clk_en && take_sample) begin
      warn_cnt_reg <= warn_cnt_next;
    end
  end

  // critical queue, same stepping as the warning queue
  always_ff @(posedge core_clk) begin
    if (srst) begin
      crit_cnt_reg <= 3'h0;
    end else if (clk_en && take_sample) begin
      crit_cnt_reg <= crit_cnt_next;
    end
  end

  // warning state; a new fault in the same cycle as the release wins,
  // so no event is dropped by a host read racing a conversion
  always_ff @(posedge core_clk) begin
    if (srst) begin
      warn_act_reg <= 1'b0;
    end else if (clk_en) begin
      if (take_sample && warn_fire) begin
        warn_act_reg <= 1'b1;
      end else if (warn_release) begin
        warn_act_reg <= 1'b0;
      end
    end
  end

  // critical state, same set-wins priority
  always_ff @(posedge core_clk) begin
    if (srst) begin
      crit_act_reg <= 1'b0;
    end else if (clk_en) begin
      if (take_sample && crit_fire) begin
        crit_act_reg <= 1'b1;
      end else if (crit_release) begin
        crit_act_reg <= 1'b0;
      end
    end
  end

  // polarity bit 0 drives the pin low when active, 1 drives it high
  always_ff @(posedge core_clk) begin
    if (srst) begin
      warn_output <= 1'b1;
    end else if (clk_en) begin
      warn_output <= cfg_reg[CFG_WPOL_BIT] ? warn_act_reg : ~warn_act_reg;
    end
  end

  // overtemperature pin; registered so a polarity write never glitches it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      overtemp_output <= 1'b1;
    end else if (clk_en) begin
      overtemp_output <= cfg_reg[CFG_OTPOL_BIT] ? crit_act_reg : ~crit_act_reg;
    end
  end

  // read strobe one cycle after the command, for every read code
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_cmd;
    end
  end

  // read word holds until the next read; unknown read codes return zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_data <= 16'h0000;
    end else if (clk_en && rd_cmd) begin
      if (temp_read) begin
        rd_data <= temp_reg;
      end else if (rd_cfg) begin
        rd_data <= cfg_reg;
      end else if (rd_hyst) begin
        rd_data <= hyst_reg;
      end else if (rd_crit) begin
        rd_data <= crit_reg;
      end else if (rd_low) begin
        rd_data <= low_reg;
      end else if (rd_high) begin
        rd_data <= high_reg;
      end else begin
        rd_data <= 16'h0000;
      end
    end
  end

endmodule

`default_nettype wire

// ==== tsr_core_sva.sv ====
// tsr_core_sva: port-level checks of the register core.
// assumes one core_clk domain with synchronous srst; bound onto every tsr_core.
`timescale 1ns/1ps
`default_nettype none
module tsr_core_sva
  import tsr_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        clk_en,
  input wire logic        cmd_valid,
  input wire tsr_cmd_t    cmd_req,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic        sample_valid,
  input wire logic [12:0] sample_temp,
  input wire logic        conv_enable,
  input wire logic        warn_output,
  input wire logic        overtemp_output
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // a command counts only on an enabled edge
  wire rd_go  = cmd_valid && clk_en && cmd_req.cmd[6];
  wire wr_cfg = cmd_valid && clk_en && (cmd_req.cmd == CMD_WR_CFG);
  property p_rd_pulse; rd_go |=> rd_valid; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read answer missing");
  property p_no_answer; clk_en && !rd_go |=> !rd_valid && $stable(rd_data); endproperty
  a_no_answer: assert property (p_no_answer) else $error("answer without read");
  property p_cfg_mask; rd_go && cmd_req.cmd == CMD_RD_CFG |=> (rd_data & 16'hE0FF) == 16'h0000; endproperty
  a_cfg_mask: assert property (p_cfg_mask) else $error("unused cfg bit set");
  property p_lim_mask; rd_go && cmd_req.cmd[3:0] > 4'h4 |=> rd_data[6:0] == 7'h00; endproperty
  a_lim_mask: assert property (p_lim_mask) else $error("limit low bits set");
  property p_conv_wr; wr_cfg |=> conv_enable == !$past(cmd_req.wdata[8]); endproperty
  a_conv_wr: assert property (p_conv_wr) else $error("shutdown bit ignored");
  property p_conv_keep; clk_en && !wr_cfg |=> $stable(conv_enable); endproperty
  a_conv_keep: assert property (p_conv_keep) else $error("shutdown state lost");
  // outputs freeze in shutdown once no command arrived this cycle or the one before
  property p_shdn_hold; !conv_enable && !cmd_valid && !$past(cmd_valid) |=> $stable({warn_output, overtemp_output}); endproperty
  a_shdn_hold: assert property (p_shdn_hold) else $error("alarm moved in shutdown");
  property p_rst_out; $fell(srst) |-> !rd_valid && rd_data == 16'h0000 && warn_output && overtemp_output && conv_enable; endproperty
  a_rst_out: assert property (p_rst_out) else $error("bad state after reset");
endmodule
bind tsr_core tsr_core_sva u_sva (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .cmd_valid(cmd_valid),
  .cmd_req(cmd_req), .rd_valid(rd_valid), .rd_data(rd_data), .sample_valid(sample_valid),
  .sample_temp(sample_temp), .conv_enable(conv_enable), .warn_output(warn_output),
  .overtemp_output(overtemp_output));
`default_nettype wire

// ==== tsr_host.sv ====
// tsr_host: behavioural host handing whole command words to the core.
// assumes it is the only driver of the command port.
`timescale 1ns/1ps
`default_nettype none
module tsr_host
  import tsr_pkg::*;
(
  input  wire logic core_clk,
  output var logic  cmd_valid,
  output var tsr_cmd_t cmd_req
);
  initial begin
    cmd_valid = 1'b0;
    cmd_req   = '0;
  end
  // drive after the edge, hold through the taking edge; calling again gives back to back
  task automatic send(input logic [7:0] c, input logic [15:0] w);
    @(posedge core_clk);
    #2;
    cmd_valid = 1'b1;
    cmd_req   = '{cmd: c, wdata: w};
  endtask
  // released word is scrambled so nothing leans on stale bits
  task automatic idle();
    @(posedge core_clk);
    #2;
    cmd_valid = 1'b0;
    cmd_req   = ~cmd_req;
  endtask
endmodule
`default_nettype wire

// ==== tb_temp_sensor_register_core.sv ====
// tb_temp_sensor_register_core: register table, then readings, alarms, queue, shutdown, reset.
// assumes tsr_pkg, tsr_core, tsr_core_sva and tsr_host compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_temp_sensor_register_core
  import tsr_pkg::*;
;
  typedef struct packed {logic [7:0] wc; logic [15:0] wd; logic [7:0] rc; logic [15:0] ex;} tsr_row_t;
  logic        core_clk;
  logic        srst;
  logic        clk_en;
  logic        sample_valid;
  logic [12:0] sample_temp;
  logic        cmd_valid;
  tsr_cmd_t    cmd_req;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic        conv_enable;
  logic        warn_output;
  logic        overtemp_output;
  int          num_errors;
  int          samples_checked;
  // write code 00 is unknown and must be dropped
  localparam tsr_row_t ROWS [14] = '{
    '{8'h00, 16'hFFFF, 8'hC5, 16'h0100},
    '{8'h00, 16'hFFFF, 8'hC7, 16'h2800},
    '{8'h00, 16'hFFFF, 8'hC9, 16'h0500},
    '{8'h00, 16'hFFFF, 8'hCB, 16'h2000},
    '{8'h00, 16'hFFFF, 8'hC3, 16'h0000},
    '{8'h81, 16'hFFFF, 8'hC1, 16'h0000},
    '{8'h83, 16'hE0FF, 8'hC3, 16'h0000},
    '{8'h85, 16'hFFFF, 8'hC5, 16'hFF80},
    '{8'h85, 16'h017F, 8'hC5, 16'h0100},
    '{8'h87, 16'h197F, 8'hC7, 16'h1900},
    '{8'h89, 16'h807F, 8'hC9, 16'h8000},
    '{8'h89, 16'h0500, 8'hC9, 16'h0500},
    '{8'h8B, 16'h7FFF, 8'hCB, 16'h7F80},
    '{8'h8B, 16'h2000, 8'h41, 16'h0000}};
  tsr_host u_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_req(cmd_req));
  // clk_en is dropped once near the end to prove that commands and samples freeze
  tsr_core u_dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_req(cmd_req),
    .rd_valid(rd_valid), .rd_data(rd_data), .sample_valid(sample_valid), .sample_temp(sample_temp),
    .conv_enable(conv_enable), .warn_output(warn_output), .overtemp_output(overtemp_output));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read answer shows right after the taking edge
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    u_host.send(c, 16'h0000);
    u_host.idle();
    chk({15'h0000, rd_valid}, 16'h0001);
    chk(rd_data, exp);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] w);
    u_host.send(c, w);
    u_host.idle();
    u_host.idle();
  endtask
  // one-cycle strobe, one queue step; pins settle the edge after the taking edge
  task automatic smp(input logic [12:0] t);
    @(posedge core_clk);
    #2;
    sample_valid = 1'b1;
    sample_temp  = t;
    @(posedge core_clk);
    #2;
    sample_valid = 1'b0;
    sample_temp  = ~t;
    @(posedge core_clk);
    #2;
  endtask
  task automatic pins(input logic [1:0] exp);
    chk({14'h0000, warn_output, overtemp_output}, {14'h0000, exp});
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    sample_valid = 1'b0;
    sample_temp = 13'h0000;
    num_errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge core_clk);
    #2;
    srst = 1'b0;
    foreach (ROWS[i]) begin
      u_host.send(ROWS[i].wc, ROWS[i].wd);
      rd(ROWS[i].rc, ROWS[i].ex);
    end
    // limits now hyst 2, crit 50, low 10, high 64 degrees
    smp(13'h0190);
    rd(CMD_RD_TEMP, 16'h0C80);
    pins(2'b11);
    smp(13'h1E70);
    rd(CMD_RD_TEMP, 16'hF382);
    pins(2'b01);
    smp(13'h03C0);
    rd(CMD_RD_TEMP, 16'h1E01);
    pins(2'b10);
    smp(13'h0310);
    pins(2'b10);
    smp(13'h02F0);
    pins(2'b11);
    wr(CMD_WR_CFG, 16'h1000);
    for (int i = 0; i < 4; i++) begin
      smp(13'h03C0);
      pins({1'b1, i < 3});
    end
    wr(CMD_WR_CFG, 16'h0400);
    pins(2'b11);
    smp(13'h0140);
    pins(2'b10);
    wr(CMD_WR_CFG, 16'h0800);
    pins(2'b01);
    wr(CMD_WR_CFG, 16'h0100);
    chk({15'h0000, conv_enable}, 16'h0000);
    smp(13'h03C0);
    pins(2'b11);
    rd(CMD_RD_TEMP, 16'h0A00);
    u_host.send(CMD_WR_HIGH, 16'h3000);
    rd(CMD_RD_HIGH, 16'h3000);
    wr(CMD_WR_CFG, 16'h0000);
    chk({15'h0000, conv_enable}, 16'h0001);
    // interrupt mode: hysteresis no longer releases, a temperature read does
    wr(CMD_WR_CFG, 16'h0200);
    smp(13'h03C0);
    pins(2'b10);
    smp(13'h0140);
    pins(2'b10);
    rd(CMD_RD_TEMP, 16'h0A00);
    u_host.idle();
    pins(2'b11);
    // clock enable low: write and sample are both ignored
    clk_en = 1'b0;
    wr(CMD_WR_HIGH, 16'h1000);
    smp(13'h03C0);
    pins(2'b11);
    clk_en = 1'b1;
    rd(CMD_RD_HIGH, 16'h3000);
    rd(CMD_RD_TEMP, 16'h0A00);
    // second reset in mid-run
    srst = 1'b1;
    @(posedge core_clk);
    #2;
    srst = 1'b0;
    rd(CMD_RD_HIGH, 16'h2000);
    rd(CMD_RD_TEMP, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
